/* File: common/wlp_pkg.sv */
/*
 * Constants and state type shared by the watchdog low-power block.
 * Assumes a single 200 MHz system clock; no other surroundings.
 */
package wlp_pkg;
   // ************************************************************
   // Counter layout and reset values
   // ************************************************************
   localparam int CNT_W = 7;
   localparam int CNT_TOP_BIT = 6;
   localparam logic [6:0] CNT_RESET = 7'h7F;
   localparam int CTRL_ACT_BIT = 7;

   // ************************************************************
   // Timing counts
   // ************************************************************
   localparam int PRESCALE_CYCLES = 16384;
   localparam int RESTART_SHORT_CYCLES = 256;
   localparam int RESTART_LONG_CYCLES = 4096;
   localparam int DLY_W = 12;
   localparam logic [11:0] RESTART_SHORT_LOAD = 12'(RESTART_SHORT_CYCLES - 1);
   localparam logic [11:0] RESTART_LONG_LOAD = 12'(RESTART_LONG_CYCLES - 1);

   // ************************************************************
   // Power states seen by the watchdog
   // ************************************************************
   typedef enum logic [2:0] {
      WLP_RUN,
      WLP_HALT_LAST,
      WLP_HALT_FROZEN,
      WLP_ACTIVE_HALT,
      WLP_RESTART_WAIT
   } wlp_state_type;
endpackage

/* File: hdl/wlp_delay_timer.sv */
/*
 * Restart delay timer: after a start pulse, counts the short or long
 * restart delay and gives a one-cycle done pulse.
 * Assumes start and long_sel come from logic on the same clock.
 */
`timescale 1ns/10ps
module wlp_delay_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic long_sel,
   // Status
   output logic done_q
);
   import wlp_pkg::*;

   logic [DLY_W-1:0] cnt_q;
   logic [DLY_W-1:0] cnt_d;
   logic busy_q;
   wire last_count = busy_q && (cnt_q == '0);

   // Load value picked from the static delay choice
   assign cnt_d = start ? (long_sel ? RESTART_LONG_LOAD : RESTART_SHORT_LOAD)
                        : (busy_q ? cnt_q - 12'h001 : cnt_q);

   // Counter, busy flag and done pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= start | (busy_q & ~last_count);
         done_q <= last_count & ~start;
      end
   end
endmodule

/* File: hdl/wlp_watchdog.sv */
/*
 * Free-running 7-bit watchdog downcounter with its low-power behaviour:
 * plain halt, active halt, halt-reset option, restart delays and the
 * always-on hardware option.
 * Assumes core strobes and option levels are synchronous to clk; rst is
 * the system reset and also releases any halt.
 */
`timescale 1ns/10ps
module wlp_watchdog #(
   parameter int PRESCALE = wlp_pkg::PRESCALE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Core power-mode and interrupt strobes
   input wire logic halt_req,
   input wire logic ext_irq_wake,
   input wire logic osc_irq_wake,
   // Static options
   input wire logic hw_watchdog_option,
   input wire logic halt_reset_option,
   input wire logic periodic_wakeup_irq_enable,
   input wire logic long_restart_delay,
   // Software write of the control word
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   // Status
   output logic [6:0] counter_q,
   output logic watchdog_activation_bit_q,
   output logic halted_q,
   output logic watchdog_reset_q
);
   import wlp_pkg::*;

   // ************************************************************
   // Prescaler
   // ************************************************************
   localparam int PS_W = $clog2(PRESCALE);
   localparam logic [PS_W-1:0] PS_LAST = PS_W'(PRESCALE - 1);

   logic [PS_W-1:0] ps_q;
   wire tick = (ps_q == PS_LAST);

   // Free-running divider; runs in every state, only the counter freezes.
   // A counter write does not clear its phase, so the first step after a
   // write lands anywhere within one prescale period
   always_ff @(posedge clk) begin
      if (rst) begin
         ps_q <= '0;
      end else begin
         ps_q <= tick ? '0 : ps_q + 1'b1;
      end
   end

   // ************************************************************
   // Power state machine
   // ************************************************************
   wlp_state_type state_q;
   wlp_state_type state_d;
   logic delay_start;
   logic delay_done;
   logic active;
   logic halt_to_reset;

   assign active = watchdog_activation_bit_q | hw_watchdog_option;
   assign halt_to_reset = halt_req & ~periodic_wakeup_irq_enable & halt_reset_option;

   // ************************************************************
   // Halt and wake decoding
   // ************************************************************
   logic halt_to_active;
   logic halt_to_plain;
   logic plain_wake;
   logic active_wake;

   // The wakeup enable wins over the halt-reset option, so a core that
   // keeps a periodic wakeup armed never trades its halt for a reset
   assign halt_to_active = halt_req & periodic_wakeup_irq_enable;
   assign halt_to_plain = halt_req & ~periodic_wakeup_irq_enable & ~halt_reset_option;
   // The prescaler keeps running in plain halt, but only the external line
   // can end it; active halt takes either source
   assign plain_wake = ext_irq_wake;
   assign active_wake = ext_irq_wake | osc_irq_wake;

   // States:
   //   run          counting on every prescaler tick
   //   halt last    plain halt, one more decrement still owed
   //   halt frozen  plain halt, count held, no expiry possible
   //   active halt  count held, a wake resumes counting at once
   //   restart wait count held until the restart delay runs out
   // Next state from halt entry and wake-up strobes
   always_comb begin
      state_d = state_q;
      case (state_q)
         WLP_RUN: begin
            if (halt_to_active) begin
               state_d = WLP_ACTIVE_HALT;
            end else if (halt_to_plain) begin
               state_d = WLP_HALT_LAST;
            end
         end
         WLP_HALT_LAST: begin
            if (plain_wake) begin
               state_d = WLP_RESTART_WAIT;
            end else if (tick) begin
               state_d = WLP_HALT_FROZEN;
            end
         end
         WLP_HALT_FROZEN: begin
            if (plain_wake) begin
               state_d = WLP_RESTART_WAIT;
            end
         end
         WLP_ACTIVE_HALT: begin
            if (active_wake) begin
               state_d = WLP_RUN;
            end
         end
         WLP_RESTART_WAIT: begin
            if (delay_done) begin
               state_d = WLP_RUN;
            end
         end
         default: state_d = WLP_RUN;
      endcase
   end

   // Delay starts on the way into the wait state
   assign delay_start = (state_d == WLP_RESTART_WAIT) && (state_q != WLP_RESTART_WAIT);

   // A system reset always ends in the wait state, so both halt kinds
   // left by reset resume counting only after the restart delay
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= WLP_RESTART_WAIT;
      end else begin
         state_q <= state_d;
      end
   end

   // Restart delay timer; its first start is the reset release itself
   logic rst_seen_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
      end
   end

   wlp_delay_timer u_delay (
      .clk(clk),
      .rst(rst),
      .start(delay_start | ~rst_seen_q),
      .long_sel(long_restart_delay),
      .done_q(delay_done)
   );

   // ************************************************************
   // Counter, activation and reset request
   // ************************************************************
   logic counting;
   logic [6:0] counter_d;
   logic expired;

   // Counter decrements in run state and for the one last step of plain halt
   assign counting = tick && ((state_q == WLP_RUN) || (state_q == WLP_HALT_LAST));
   assign counter_d = ctrl_wr ? ctrl_wdata[CNT_W-1:0]
                              : (counting ? counter_q - 7'h01 : counter_q);

   // Top bit of the count; its fall from 40h to 3Fh is the expiry
   logic counter_top_bit;
   assign counter_top_bit = counter_q[CNT_TOP_BIT];

   // Frozen and waiting states cannot fire; a write of top bit 0 fires too.
   // Limitation: a count left below 40h by a plain halt fires as soon as
   // the restart wait ends, so software should refresh before halting
   assign expired = active && !counter_top_bit && (state_q == WLP_RUN);

   // Activation only rises; rst is the single way back to disabled
   always_ff @(posedge clk) begin
      if (rst) begin
         counter_q <= CNT_RESET;
         watchdog_activation_bit_q <= 1'b0;
      end else begin
         counter_q <= counter_d;
         watchdog_activation_bit_q <= watchdog_activation_bit_q |
            (ctrl_wr & ctrl_wdata[CTRL_ACT_BIT]);
      end
   end

   // Halt flag follows the next state so the core sees it one edge after
   // its request; the restart wait does not count as a halt
   logic halted_d;
   assign halted_d = (state_d == WLP_HALT_LAST) || (state_d == WLP_HALT_FROZEN) ||
      (state_d == WLP_ACTIVE_HALT);

   // Reset request is held until the system reset answers it
   always_ff @(posedge clk) begin
      if (rst) begin
         watchdog_reset_q <= 1'b0;
         halted_q <= 1'b0;
      end else begin
         watchdog_reset_q <= watchdog_reset_q | expired |
            (halt_to_reset && state_q == WLP_RUN);
         halted_q <= halted_d;
      end
   end
endmodule

/* File: tb/wlp_core_model.sv */
/*
 * Core-side model: gives halt and wake strobes to the watchdog.
 * Assumes the bench calls pulse from a falling edge of clk.
 */
`timescale 1ns/10ps
module wlp_core_model (
   // Clock
   input wire logic clk,
   // Strobes to the watchdog
   output logic halt_req,
   output logic ext_irq_wake,
   output logic osc_irq_wake
);
   // One-cycle strobe launched on the falling edge, clear of the sampling edge
   task automatic pulse(input int k);
      halt_req = (k == 0);
      ext_irq_wake = (k == 1);
      osc_irq_wake = (k == 2);
      @(negedge clk);
      {halt_req, ext_irq_wake, osc_irq_wake} = 3'h0;
   endtask
   initial begin
      {halt_req, ext_irq_wake, osc_irq_wake} = 3'h0;
   end
endmodule

/* File: tb/wlp_watchdog_chk.sv */
/*
 * Assertion checker for the watchdog low-power block.
 * Sees only ports of wlp_watchdog; bound after the module.
 */
`timescale 1ns/10ps
module wlp_watchdog_chk #(
   parameter int PRESCALE = 16
) (
   // Clock, reset and inputs
   input wire logic clk,
   input wire logic rst,
   input wire logic halt_req,
   input wire logic hw_watchdog_option,
   input wire logic halt_reset_option,
   input wire logic periodic_wakeup_irq_enable,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   // Status
   input wire logic [6:0] counter_q,
   input wire logic watchdog_activation_bit_q,
   input wire logic halted_q,
   input wire logic watchdog_reset_q
);
   // Able to reset, by software or by option
   wire act = watchdog_activation_bit_q | hw_watchdog_option;
   wire pwe = periodic_wakeup_irq_enable;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ************************************************************
   // Properties
   // ************************************************************
   property p_halt_plain; halt_req && !pwe && !halt_reset_option && !act |=> !watchdog_reset_q;
   endproperty
   a_halt_plain: assert property (p_halt_plain) else $error("plain halt reset");
   property p_halt_rst; halt_req && !pwe && halt_reset_option && !halted_q |=> !halted_q;
   endproperty
   a_halt_rst: assert property (p_halt_rst) else $error("halted not reset");
   // Stale decrement may land, then the count must sit still for the next 8 cycles
   property p_frz; halted_q && $past(halted_q) && !pwe && $changed(counter_q)
      |=> ($stable(counter_q) || !halted_q) [*8]; endproperty
   a_frz: assert property (p_frz) else $error("plain halt counting");
   property p_ah; halted_q && pwe && !ctrl_wr |=> $stable(counter_q) || !halted_q; endproperty
   a_ah: assert property (p_ah) else $error("active halt counting");
   property p_exp; act && !counter_q[6] && !halted_q |=> watchdog_reset_q; endproperty
   a_exp: assert property (p_exp) else $error("no expiry reset");
   property p_keep; watchdog_activation_bit_q |=> watchdog_activation_bit_q; endproperty
   a_keep: assert property (p_keep) else $error("activation lost");
   property p_set; $rose(watchdog_activation_bit_q) |-> $past(ctrl_wr && ctrl_wdata[7]);
   endproperty
   a_set: assert property (p_set) else $error("activation unasked");
   property p_dec; $changed(counter_q) && !$past(ctrl_wr) |-> counter_q == $past(counter_q) - 7'h01;
   endproperty
   a_dec: assert property (p_dec) else $error("counter step");
endmodule
bind wlp_watchdog wlp_watchdog_chk #(.PRESCALE(PRESCALE)) i_wlp_watchdog_chk (.*);

/* File: tb/wlp_watchdog_tb.sv */
/*
 * Testbench for the watchdog low-power block, prescale shortened to 16.
 * Assumes wlp_core_model drives the core strobes.
 */
`timescale 1ns/10ps
module wlp_watchdog_tb;
   import wlp_pkg::*;
   logic clk = 1'b0, rst = 1'b1, hw_watchdog_option, halt_reset_option;
   logic periodic_wakeup_irq_enable, long_restart_delay, ctrl_wr;
   logic [7:0] ctrl_wdata;
   logic [6:0] counter_q, c;
   logic watchdog_activation_bit_q, halted_q, watchdog_reset_q, halt_req, ext_irq_wake;
   logic osc_irq_wake;
   int err_count = 0, tests_run = 0, cyc = 0, n;
   always #2.5 clk = ~clk;
   wlp_watchdog #(.PRESCALE(16)) i_wlp_watchdog (.*);
   wlp_core_model i_wlp_core_model (.*);
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(string s, logic [6:0] seen, logic [6:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic do_rst;
      rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
   endtask
   // Cycles until the counter moves; bounded so a stuck count cannot hang
   task automatic wchg;
      c = counter_q;
      n = 0;
      while (counter_q === c && n < 5000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic wr(logic [7:0] d);
      ctrl_wr = 1'b1;
      ctrl_wdata = d;
      @(negedge clk);
      ctrl_wr = 1'b0;
      // Idle cycle so a following write raises the strobe afresh
      @(negedge clk);
   endtask
   task automatic wrst(int lim);
      n = 0;
      while (watchdog_reset_q !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim;
      end
   end
   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      {hw_watchdog_option, halt_reset_option, periodic_wakeup_irq_enable} = 3'h0;
      {long_restart_delay, ctrl_wr} = 2'h0;
      ctrl_wdata = 8'h00;
      do_rst;
      chk("cnt", counter_q, 7'h7F);
      chk("act", watchdog_activation_bit_q, 1'b0);
      wchg;
      chk("dly", n >= 256 && n <= 280, 1'b1);
      wchg;
      chk("tick", 7'(n), 7'd16);
      wchg;
      c = counter_q;
      i_wlp_core_model.pulse(0);
      chk("halt", halted_q, 1'b1);
      repeat (64) @(negedge clk);
      chk("frz", counter_q, c - 7'h01);
      i_wlp_core_model.pulse(1);
      wchg;
      chk("wake", n >= 256 && n <= 280, 1'b1);
      // Active halt, each wake source, halt-reset option both ways
      periodic_wakeup_irq_enable = 1'b1;
      for (int i = 1; i < 3; i++) begin
         halt_reset_option = i[0];
         wchg;
         i_wlp_core_model.pulse(0);
         repeat (64) @(negedge clk);
         chk("ahc", counter_q, c - 7'h01);
         chk("ahr", watchdog_reset_q, 1'b0);
         i_wlp_core_model.pulse(i);
         wchg;
         chk("imm", n <= 18, 1'b1);
      end
      periodic_wakeup_irq_enable = 1'b0;
      halt_reset_option = 1'b0;
      wr(8'hC2);
      wr(8'h45);
      chk("keep", watchdog_activation_bit_q, 1'b1);
      wrst(200);
      chk("exp", counter_q, 7'h3F);
      do_rst;
      wchg;
      halt_reset_option = 1'b1;
      i_wlp_core_model.pulse(0);
      chk("hrst", watchdog_reset_q, 1'b1);
      chk("hrsh", halted_q, 1'b0);
      halt_reset_option = 1'b0;
      do_rst;
      wchg;
      // Armed watchdog goes into plain halt, then a reset ends that halt
      wr(8'hFF);
      i_wlp_core_model.pulse(0);
      chk("ahlt", halted_q, 1'b1);
      chk("anor", watchdog_reset_q, 1'b0);
      do_rst;
      chk("off", watchdog_activation_bit_q, 1'b0);
      wchg;
      periodic_wakeup_irq_enable = 1'b1;
      long_restart_delay = 1'b1;
      i_wlp_core_model.pulse(0);
      do_rst;
      wchg;
      chk("long", n >= 4096 && n <= 4120, 1'b1);
      long_restart_delay = 1'b0;
      hw_watchdog_option = 1'b1;
      do_rst;
      wrst(1400);
      chk("hw", watchdog_reset_q, 1'b1);
      end_sim;
   end
endmodule
